// ### logic/icx_irq.sv
// Interrupt request gating for error and event sources
`timescale 1ns/100ps
`include "icx_params.svh"
module icx_irq
  import icx_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  icx_core_if.irq core
);

  logic next_err;
  logic next_evt;
  logic buf_ev;

  always_comb begin
    next_err = core.err_en & (|core.err_flags);
    // Data events are visible only with the buffer enable
    buf_ev = core.buf_en & (core.evt[`ICX_EV_TXE] |
      core.evt[`ICX_EV_RECEIVE_FULL_FLAG]);
    next_evt = core.evt_en & (core.evt[`ICX_EV_START] |
      core.evt[`ICX_EV_ADDR] | core.evt[`ICX_EV_TEN] |
      core.evt[`ICX_EV_STOP] |
      (core.evt[`ICX_EV_BTF] & ~core.evt[`ICX_EV_TXE] &
        ~core.evt[`ICX_EV_RECEIVE_FULL_FLAG]) |
      buf_ev | core.wake_flag);
  end

  // Levels follow their sources, one cycle behind
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core.err_irq <= 1'b0;
      core.evt_irq <= 1'b0;
    end else begin
      core.err_irq <= next_err;
      core.evt_irq <= next_evt;
    end
  end

endmodule

// ### logic/icx_scl_gen.sv
// Master SCL generator: high and low phases from the divider
`timescale 1ns/100ps
`include "icx_params.svh"
module icx_scl_gen
  import icx_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  icx_core_if.scl core
);

  icx_scl_state_t state;
  logic [`ICX_CNT_W-1:0] cnt;
  logic [`ICX_CNT_W-1:0] div_w;
  logic [`ICX_CNT_W-1:0] high_len;
  logic [`ICX_CNT_W-1:0] low_len;
  logic held_low;

  always_comb begin
    div_w = {{(`ICX_CNT_W-`ICX_DIV_W){1'b0}}, core.divider};
    high_len = div_w;
    low_len = div_w;
    if (core.fast && core.duty) begin
      high_len = `ICX_CNT_W'(div_w * `ICX_MUL_DUTY_HI);
      low_len = `ICX_CNT_W'(div_w * `ICX_MUL_DUTY_LO);
    end else if (core.fast) begin
      low_len = `ICX_CNT_W'(div_w * `ICX_MUL_FAST_LO);
    end
    // A slave still holding SCL after the rise budget stretches high
    held_low = !core.scl_in &&
      (cnt >= {{(`ICX_CNT_W-`ICX_RISE_W){1'b0}}, core.rise});
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= icx_scl_idle;
      cnt <= `ICX_CNT_ONE;
      core.scl_oe <= 1'b0;
    end else if (!core.run || core.divider == `ICX_RST_DIV) begin
      state <= icx_scl_idle;
      cnt <= `ICX_CNT_ONE;
      core.scl_oe <= 1'b0;
    end else begin
      case (state)
        icx_scl_idle: begin
          state <= icx_scl_low;
          cnt <= `ICX_CNT_ONE;
          core.scl_oe <= 1'b1;
        end
        icx_scl_low: begin
          if (cnt >= low_len) begin
            state <= icx_scl_high;
            cnt <= `ICX_CNT_ONE;
            core.scl_oe <= 1'b0;
          end else begin
            cnt <= cnt + `ICX_CNT_ONE;
          end
        end
        icx_scl_high: begin
          if (held_low) begin
            cnt <= cnt;
          end else if (cnt >= high_len) begin
            state <= icx_scl_low;
            cnt <= `ICX_CNT_ONE;
            core.scl_oe <= 1'b1;
          end else begin
            cnt <= cnt + `ICX_CNT_ONE;
          end
        end
        default: begin
          state <= icx_scl_idle;
          cnt <= `ICX_CNT_ONE;
          core.scl_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### logic/icx_top.sv
// I2C interrupt enables, error flags and SCL timing behind an AHB-Lite slave
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "icx_params.svh"
module icx_top
  import icx_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic master_mode,
  input wire logic halt_mode,
  input wire logic start_sent_flag,
  input wire logic address_done_flag,
  input wire logic ten_bit_header_flag,
  input wire logic stop_seen_flag,
  input wire logic byte_finished_flag,
  input wire logic transmit_empty_flag,
  input wire logic receive_full_flag,
  input wire logic misplaced_condition_set,
  input wire logic arbitration_lost_set,
  input wire logic ack_failure_set,
  input wire logic overrun_set,
  input wire logic address_match_set,
  input wire logic scl_in,
  output logic scl_o,
  output logic scl_oe,
  output logic peripheral_enable,
  output logic error_irq,
  output logic event_irq
);

  icx_core_if core ();

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  icx_bus_state_t bus_state;
  logic [`ICX_IDX_W-1:0] cap_idx;
  logic cap_write;
  logic error_irq_enable;
  logic event_irq_enable;
  logic buffer_irq_enable;
  logic [`ICX_DIV_W-1:0] scl_divider;
  logic fast_mode;
  logic fast_duty;
  logic [`ICX_RISE_W-1:0] rise_time_count;
  logic [`ICX_NUM_ERR-1:0] err_flags;
  logic [`ICX_NUM_ERR-1:0] err_set;
  logic halt_wakeup_flag;
  logic halt_entered;
  logic halt_seen;
  logic wake_set;
  logic addr_ok;
  logic do_write;
  logic do_read;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state so reads see the preceding write

  // Only word-aligned addresses inside the register window are decoded, whatever hsize; others read zero
  assign addr_ok = (haddr[1:0] == 2'h0) && (haddr[31:`ICX_IDX_MSB+1] == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= icx_bus_addr;
      cap_idx <= '0;
      cap_write <= 1'b0;
      hreadyout <= 1'b1;
    end else begin
      case (bus_state)
        icx_bus_addr: begin
          if (hsel && htrans[1] && hready) begin
            bus_state <= icx_bus_data;
            cap_idx <= addr_ok ? haddr[`ICX_IDX_MSB:`ICX_IDX_LSB] :
              {`ICX_IDX_W{1'b1}};
            cap_write <= hwrite;
            hreadyout <= 1'b0;
          end
        end
        icx_bus_data: begin
          bus_state <= icx_bus_addr;
          hreadyout <= 1'b1;
        end
        default: begin
          bus_state <= icx_bus_addr;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  assign do_write = (bus_state == icx_bus_data) && cap_write;
  assign do_read = (bus_state == icx_bus_data) && !cap_write;
  assign wbyte = hwdata[7:0];

  // Every transfer answers OKAY, unmapped ones included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and configuration registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peripheral_enable <= 1'b0;
    end else if (do_write && cap_idx == `ICX_IDX_CTRL) begin
      peripheral_enable <= wbyte[`ICX_BIT_PE];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      error_irq_enable <= 1'b0;
      event_irq_enable <= 1'b0;
      buffer_irq_enable <= 1'b0;
    end else if (do_write && cap_idx == `ICX_IDX_IRQ_EN) begin
      error_irq_enable <= wbyte[`ICX_BIT_ERR_EN];
      event_irq_enable <= wbyte[`ICX_BIT_EVT_EN];
      buffer_irq_enable <= wbyte[`ICX_BIT_BUF_EN];
    end
  end

  // Timing fields are taken as written; software keeps them stable
  // while enabled, the hardware does not lock them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_divider <= `ICX_RST_DIV;
      fast_mode <= 1'b0;
      fast_duty <= 1'b0;
    end else if (do_write && cap_idx == `ICX_IDX_DIV_LO) begin
      scl_divider[7:0] <= wbyte;
    end else if (do_write && cap_idx == `ICX_IDX_DIV_HI) begin
      scl_divider[`ICX_DIV_W-1:8] <=
        wbyte[`ICX_DIV_HI_MSB:`ICX_DIV_HI_LSB];
      fast_mode <= wbyte[`ICX_BIT_FAST];
      fast_duty <= wbyte[`ICX_BIT_DUTY];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_time_count <= `ICX_RST_RISE;
    end else if (do_write && cap_idx == `ICX_IDX_RISE) begin
      rise_time_count <= wbyte[`ICX_RISE_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: hardware set wins over a software clear

  assign err_set[`ICX_BIT_MISPLACED] = misplaced_condition_set;
  assign err_set[`ICX_BIT_ARB_LOST] = arbitration_lost_set;
  assign err_set[`ICX_BIT_ACK_FAIL] = ack_failure_set;
  assign err_set[`ICX_BIT_OVERRUN] = overrun_set;

  genvar gi;
  generate
    for (gi = 0; gi < `ICX_NUM_ERR; gi = gi + 1) begin : g_err
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          err_flags[gi] <= 1'b0;
        end else if (!peripheral_enable) begin
          err_flags[gi] <= 1'b0;
        end else if (err_set[gi]) begin
          err_flags[gi] <= 1'b1;
        end else if (do_write && cap_idx == `ICX_IDX_STATUS &&
            !wbyte[gi]) begin
          err_flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Entry into halt as master is seen on the rising edge of halt_mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_seen <= 1'b0;
    end else begin
      halt_seen <= halt_mode;
    end
  end

  assign halt_entered = halt_mode && !halt_seen && master_mode;
  assign wake_set = event_irq_enable &&
    ((address_match_set && halt_mode && !master_mode) || halt_entered);

  // Single clock here, so the wakeup is caught on the next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_wakeup_flag <= 1'b0;
    end else if (!peripheral_enable) begin
      halt_wakeup_flag <= 1'b0;
    end else if (wake_set) begin
      halt_wakeup_flag <= 1'b1;
    end else if (do_write && cap_idx == `ICX_IDX_STATUS &&
        !wbyte[`ICX_BIT_WAKE]) begin
      halt_wakeup_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, reserved bits read zero

  always_comb begin
    rbyte = `ICX_RST_BYTE;
    case (cap_idx)
      `ICX_IDX_CTRL: rbyte[`ICX_BIT_PE] = peripheral_enable;
      `ICX_IDX_STATUS: begin
        rbyte[`ICX_NUM_ERR-1:0] = err_flags;
        rbyte[`ICX_BIT_WAKE] = halt_wakeup_flag;
      end
      `ICX_IDX_IRQ_EN: begin
        rbyte[`ICX_BIT_ERR_EN] = error_irq_enable;
        rbyte[`ICX_BIT_EVT_EN] = event_irq_enable;
        rbyte[`ICX_BIT_BUF_EN] = buffer_irq_enable;
      end
      `ICX_IDX_DIV_LO: rbyte = scl_divider[7:0];
      `ICX_IDX_DIV_HI: begin
        rbyte[`ICX_DIV_HI_MSB:`ICX_DIV_HI_LSB] =
          scl_divider[`ICX_DIV_W-1:8];
        rbyte[`ICX_BIT_DUTY] = fast_duty;
        rbyte[`ICX_BIT_FAST] = fast_mode;
      end
      `ICX_IDX_RISE: rbyte[`ICX_RISE_MSB:0] = rise_time_count;
      default: rbyte = `ICX_RST_BYTE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (do_read) begin
      hrdata <= {24'h00_0000, rbyte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  assign core.run = peripheral_enable && master_mode;
  assign core.divider = scl_divider;
  assign core.fast = fast_mode;
  assign core.duty = fast_duty;
  assign core.rise = rise_time_count;
  assign core.scl_in = scl_in;
  assign core.err_flags = err_flags;
  assign core.wake_flag = halt_wakeup_flag;
  assign core.evt = {receive_full_flag, transmit_empty_flag,
    byte_finished_flag, stop_seen_flag, ten_bit_header_flag,
    address_done_flag, start_sent_flag};
  assign core.err_en = error_irq_enable;
  assign core.evt_en = event_irq_enable;
  assign core.buf_en = buffer_irq_enable;

  icx_scl_gen u_scl (
    .hclk(hclk),
    .hresetn(hresetn),
    .core(core)
  );

  icx_irq u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .core(core)
  );

  // Open-drain SCL: the pin only ever pulls low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
    end
  end

  assign scl_oe = core.scl_oe;
  assign error_irq = core.err_irq;
  assign event_irq = core.evt_irq;

endmodule

// ### pkg/icx_core_if.sv
// Signals between the register top, the SCL generator and interrupt logic
`timescale 1ns/100ps
interface icx_core_if;
  logic run;
  logic [11:0] divider;
  logic fast;
  logic duty;
  logic [5:0] rise;
  logic scl_in;
  logic scl_oe;
  logic [3:0] err_flags;
  logic wake_flag;
  logic [6:0] evt;
  logic err_en;
  logic evt_en;
  logic buf_en;
  logic err_irq;
  logic evt_irq;

  modport top (
    output run, divider, fast, duty, rise, scl_in, err_flags, wake_flag,
    output evt, err_en, evt_en, buf_en,
    input scl_oe, err_irq, evt_irq
  );
  modport scl (
    input run, divider, fast, duty, rise, scl_in,
    output scl_oe
  );
  modport irq (
    input err_flags, wake_flag, evt, err_en, evt_en, buf_en,
    output err_irq, evt_irq
  );
endinterface

// ### pkg/icx_params.svh
// Register indices, field positions, reset values and timing factors
`ifndef ICX_PARAMS_SVH
`define ICX_PARAMS_SVH

// Register index; the byte address is four times the index
`define ICX_IDX_W 10
`define ICX_IDX_CTRL 10'h000
`define ICX_IDX_STATUS 10'h008
`define ICX_IDX_IRQ_EN 10'h00a
`define ICX_IDX_DIV_LO 10'h00b
`define ICX_IDX_DIV_HI 10'h00c
`define ICX_IDX_RISE 10'h00d
`define ICX_IDX_MSB 11
`define ICX_IDX_LSB 2

// Control register
`define ICX_BIT_PE 0

// Status register, set by hardware, cleared by writing zero
`define ICX_BIT_MISPLACED 0
`define ICX_BIT_ARB_LOST 1
`define ICX_BIT_ACK_FAIL 2
`define ICX_BIT_OVERRUN 3
`define ICX_BIT_WAKE 5
`define ICX_NUM_ERR 4

// Interrupt enable register
`define ICX_BIT_ERR_EN 0
`define ICX_BIT_EVT_EN 1
`define ICX_BIT_BUF_EN 2

// Divider high byte
`define ICX_DIV_HI_LSB 0
`define ICX_DIV_HI_MSB 3
`define ICX_BIT_DUTY 6
`define ICX_BIT_FAST 7

// Rise time register
`define ICX_RISE_W 6
`define ICX_RISE_MSB 5

// Reset values
`define ICX_RST_BYTE 8'h00
`define ICX_RST_RISE 6'h02
`define ICX_RST_DIV 12'h000

// Event vector positions
`define ICX_EV_START 0
`define ICX_EV_ADDR 1
`define ICX_EV_TEN 2
`define ICX_EV_STOP 3
`define ICX_EV_BTF 4
`define ICX_EV_TXE 5
`define ICX_EV_RECEIVE_FULL_FLAG 6
`define ICX_NUM_EV 7

// SCL phase factors, counter wide enough for 25 * 4095
`define ICX_DIV_W 12
`define ICX_CNT_W 17
`define ICX_MUL_DUTY_HI 17'd9
`define ICX_MUL_DUTY_LO 17'd16
`define ICX_MUL_FAST_LO 17'd2
`define ICX_CNT_ONE 17'd1

`endif

// ### pkg/icx_pkg.sv
// Types shared by the serial clock generator and the bus slave
package icx_pkg;
  typedef enum logic [1:0] {
    icx_scl_idle,
    icx_scl_low,
    icx_scl_high
  } icx_scl_state_t;

  typedef enum logic {
    icx_bus_addr,
    icx_bus_data
  } icx_bus_state_t;
endpackage

// ### verification/icx_scl_peer.sv
// Far side of SCL: pull-up with a rise delay of RISE cycles
`timescale 1ns/100ps
module icx_scl_peer #(
  parameter int RISE = 1
) (
  input logic hclk,
  input logic scl_oe,
  output logic scl_in
);
  int rise_cnt = 0;
  // Released line is slow to climb, so the master sees a late high
  always @(posedge hclk) begin
    if (scl_oe) begin
      rise_cnt <= RISE;
    end else if (rise_cnt > 0) begin
      rise_cnt <= rise_cnt - 1;
    end
  end
  assign scl_in = !scl_oe && rise_cnt == 0;
endmodule

// ### verification/icx_top_sva.sv
// Checker: bus handshake, SCL phases and interrupt quieting
`timescale 1ns/100ps
module icx_top_sva (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  input logic master_mode,
  input logic scl_o,
  input logic scl_oe,
  input logic peripheral_enable,
  input logic error_irq,
  input logic event_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire off = !peripheral_enable || !master_mode;
  ////////////////////////////////////////////////////////////////////
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  wait_state_a: assert property (hsel && htrans[1] && hready
    |=> !hreadyout ##1 hreadyout) else $error("bad wait state");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits set");
  scl_data_a: assert property (scl_o == 1'b0)
    else $error("scl_o driven high");
  scl_master_a: assert property (off |=> !scl_oe)
    else $error("scl pulled while not running");
  // Low phase is at least four cycles for any legal divider
  scl_low_min_a: assert property ($rose(scl_oe)
    |-> (scl_oe || off)[*4]) else $error("scl low too short");
  scl_high_min_a: assert property ($fell(scl_oe)
    |-> (!scl_oe)[*4]) else $error("scl high too short");
  err_quiet_a: assert property ((!peripheral_enable)[*4]
    |-> !error_irq) else $error("error irq while disabled");
  ////////////////////////////////////////////////////////////////////
  read_c: cover property (hsel && htrans[1] && hready);
  scl_c: cover property ($rose(scl_oe));
  err_c: cover property ($rose(error_irq));
  evt_c: cover property ($rose(event_irq));
endmodule

bind icx_top icx_top_sva chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .master_mode(master_mode),
  .scl_o(scl_o),
  .scl_oe(scl_oe),
  .peripheral_enable(peripheral_enable),
  .error_irq(error_irq),
  .event_irq(event_irq)
);

// ### verification/tb_i2c_irq_enable_and_scl_timing.sv
// Bench: register access, interrupt gating and SCL phase timing
`timescale 1ns/100ps
`include "icx_params.svh"
module tb_i2c_irq_enable_and_scl_timing;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, scl_o, scl_oe, scl_in, pe, err_irq, evt_irq;
  logic mst = 0, halt = 0, amatch = 0;
  logic [6:0] ev = 0;
  logic [3:0] eset = 0;
  int errors = 0, n_compared = 0, cyc = 0, n, l, h, dv;
  logic [10:0] tv [0:8] = '{11'h260, 11'h2a0, 11'h240, 11'h280,
    11'h641, 11'h681, 11'h6a1, 11'h442, 11'h600};
  logic [15:0] st [0:5] = '{16'h0004, 16'h8004, 16'hc001, 16'h0104,
    16'hc002, 16'h4005};
  assign hready = hreadyout;
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  icx_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .master_mode(mst),
    .halt_mode(halt), .start_sent_flag(ev[0]),
    .address_done_flag(ev[1]), .ten_bit_header_flag(ev[2]),
    .stop_seen_flag(ev[3]), .byte_finished_flag(ev[4]),
    .transmit_empty_flag(ev[5]), .receive_full_flag(ev[6]),
    .misplaced_condition_set(eset[0]), .arbitration_lost_set(eset[1]),
    .ack_failure_set(eset[2]), .overrun_set(eset[3]),
    .address_match_set(amatch), .scl_in(scl_in), .scl_o(scl_o),
    .scl_oe(scl_oe), .peripheral_enable(pe), .error_irq(err_irq),
    .event_irq(evt_irq));
  icx_scl_peer #(.RISE(1)) peer (.hclk(hclk), .scl_oe(scl_oe),
    .scl_in(scl_in));
  //////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds each phase until hready is sampled high
  task automatic bus(input logic w, input logic [9:0] i,
    input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, i, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rdc(input string nm, input logic [9:0] i,
    input logic [31:0] e);
    bus(1'b0, i, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic irqs(input logic [1:0] e);
    repeat (3) @(posedge hclk);
    chk("irqs", {30'h0, e}, {30'h0, err_irq, evt_irq});
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge hclk);
    eset <= m;
    @(posedge hclk);
    eset <= 4'h0;
  endtask
  task automatic phase(input logic lv, output int k);
    k = 0;
    while (scl_oe === lv && k < 9000) begin
      @(negedge hclk);
      k++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("irq_en", `ICX_IDX_IRQ_EN, 32'h0);
    rdc("div_lo", `ICX_IDX_DIV_LO, 32'h0);
    rdc("div_hi", `ICX_IDX_DIV_HI, 32'h0);
    rdc("rise", `ICX_IDX_RISE, 32'h2);
    wr(`ICX_IDX_IRQ_EN, 8'hff);
    rdc("irq_en", `ICX_IDX_IRQ_EN, 32'h7);
    wr(`ICX_IDX_DIV_HI, 8'hff);
    rdc("div_hi", `ICX_IDX_DIV_HI, 32'hcf);
    wr(`ICX_IDX_RISE, 8'hff);
    rdc("rise", `ICX_IDX_RISE, 32'h3f);
    wr(10'h00f, 8'hff);
    rdc("unmapped", 10'h00f, 32'h0);
    wr(`ICX_IDX_RISE, 8'h02);
    wr(`ICX_IDX_DIV_HI, 8'h00);
    wr(`ICX_IDX_CTRL, 8'h01);
    chk("pe", 32'h1, {31'h0, pe});
    rdc("ctrl", `ICX_IDX_CTRL, 32'h1);
    wr(`ICX_IDX_IRQ_EN, 8'h01);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h1 << i);
      irqs(2'b10);
      wr(`ICX_IDX_STATUS, 8'h00);
      irqs(2'b00);
    end
    wr(`ICX_IDX_IRQ_EN, 8'h00);
    pulse(4'hf);
    irqs(2'b00);
    wr(`ICX_IDX_IRQ_EN, 8'h01);
    irqs(2'b10);
    wr(`ICX_IDX_CTRL, 8'h00);
    chk("pe", 32'h0, {31'h0, pe});
    irqs(2'b00);
    rdc("status", `ICX_IDX_STATUS, 32'h0);
    wr(`ICX_IDX_CTRL, 8'h01);
    wr(`ICX_IDX_IRQ_EN, 8'h02);
    for (int i = 0; i < 5; i++) begin
      ev <= 7'h01 << i;
      irqs(2'b01);
      ev <= 7'h00;
      irqs(2'b00);
    end
    // Columns: enables, event inputs, expected event request
    for (int i = 0; i < 9; i++) begin
      wr(`ICX_IDX_IRQ_EN, {5'h0, tv[i][10:8]});
      ev <= tv[i][7:1];
      irqs({1'b0, tv[i][0]});
    end
    wr(`ICX_IDX_IRQ_EN, 8'h00);
    mst <= 1'b1;
    halt <= 1'b1;
    wr(`ICX_IDX_IRQ_EN, 8'h02);
    irqs(2'b00);
    halt <= 1'b0;
    irqs(2'b00);
    halt <= 1'b1;
    irqs(2'b01);
    halt <= 1'b0;
    rdc("wake", `ICX_IDX_STATUS, 32'h20);
    wr(`ICX_IDX_STATUS, 8'h00);
    irqs(2'b00);
    mst <= 1'b0;
    halt <= 1'b1;
    @(posedge hclk);
    amatch <= 1'b1;
    @(posedge hclk);
    amatch <= 1'b0;
    irqs(2'b01);
    halt <= 1'b0;
    wr(`ICX_IDX_STATUS, 8'h00);
    irqs(2'b00);
    mst <= 1'b1;
    // Divider only changes while disabled, as software must
    for (int i = 0; i < 6; i++) begin
      wr(`ICX_IDX_CTRL, 8'h00);
      wr(`ICX_IDX_DIV_LO, st[i][7:0]);
      wr(`ICX_IDX_DIV_HI, st[i][15:8]);
      dv = {st[i][11:8], st[i][7:0]};
      h = (st[i][15] && st[i][14]) ? 9 * dv : dv;
      l = !st[i][15] ? dv : st[i][14] ? 16 * dv : 2 * dv;
      wr(`ICX_IDX_CTRL, 8'h01);
      @(negedge hclk);
      phase(1'b0, n);
      phase(1'b1, n);
      phase(1'b0, n);
      phase(1'b1, n);
      chk("scl low", l, n);
      phase(1'b0, n);
      chk("scl high", h, n);
    end
    wr(`ICX_IDX_CTRL, 8'h00);
    complete_run();
  end
endmodule
